// ---- pfc_pkg.sv ----
// constants shared by the packet framing configuration block
package pfc_pkg;
   // register offsets on the serial configuration port
   localparam logic [4:0] PFC_SYNC3_OFS = 5'h16;
   localparam logic [4:0] PFC_SYNC2_OFS = 5'h17;
   localparam logic [4:0] PFC_SYNC1_OFS = 5'h18;
   localparam logic [4:0] PFC_SYNC0_OFS = 5'h19;
   localparam logic [4:0] PFC_TXSET_OFS = 5'h1a;
   localparam logic [4:0] PFC_CLKO_OFS  = 5'h1b;
   localparam logic [4:0] PFC_CODE_OFS  = 5'h1c;
   localparam logic [4:0] PFC_NODE_OFS  = 5'h1d;
   localparam logic [4:0] PFC_FMT_OFS   = 5'h1e;
   localparam logic [4:0] PFC_FIFO_OFS  = 5'h1f;
   // reset values
   localparam logic [7:0] PFC_SYNC_RST  = 8'h00;
   localparam logic [7:0] PFC_TXSET_RST = 8'h72;
   localparam logic [7:0] PFC_CLKO_RST  = 8'hbc;
   localparam logic [7:0] PFC_CODE_RST  = 8'h00;
   localparam logic [7:0] PFC_NODE_RST  = 8'h00;
   localparam logic [7:0] PFC_FMT_RST   = 8'h48;
   localparam logic [7:0] PFC_FIFO_RST  = 8'h00;
   // field positions
   localparam int PFC_INTERP_LSB  = 4;
   localparam int PFC_POWER_LSB   = 1;
   localparam int PFC_CLKO_EN_BIT = 7;
   localparam int PFC_CLKO_DIV_LSB = 2;
   localparam int PFC_MANCH_BIT   = 7;
   localparam int PFC_FORMAT_BIT  = 7;
   localparam int PFC_PREAMB_LSB  = 5;
   localparam int PFC_WHITE_BIT   = 4;
   localparam int PFC_CRC_EN_BIT  = 3;
   localparam int PFC_AFILT_LSB   = 1;
   localparam int PFC_CRC_OK_BIT  = 0;
   localparam int PFC_AUTOCLR_BIT = 7;
   localparam int PFC_STBY_RD_BIT = 6;
   // address filter modes and broadcast codes
   typedef enum logic [1:0] {
      PFC_AF_OFF  = 2'b00,
      PFC_AF_NODE = 2'b01,
      PFC_AF_N00  = 2'b10,
      PFC_AF_NALL = 2'b11
   } pfc_afilt_e;
   localparam logic [7:0] PFC_BCAST_LO = 8'h00;
   localparam logic [7:0] PFC_BCAST_HI = 8'hff;
   // serial frame: command byte then data byte
   localparam logic [4:0] PFC_CMD_BITS   = 5'h08;
   localparam logic [4:0] PFC_FRAME_BITS = 5'h10;
endpackage

// ---- pfc_cfg_if.sv ----
// register access carrier between serial port and register file
`timescale 1ns/100ps
interface pfc_cfg_if;
   logic       wr_stb;
   logic [4:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport port (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ---- pfc_spi_port.sv ----
// serial configuration port: command byte then one data byte
`timescale 1ns/100ps
module pfc_spi_port
   import pfc_pkg::*;
(
   // clock and reset
   input  wire logic mclk_in,
   input  wire logic sys_rst_in,
   // serial pins
   input  wire logic sck_in,
   input  wire logic mosi_in,
   input  wire logic cs_n_in,
   output logic      miso_out,
   output logic      miso_oe_out,
   // register side
   pfc_cfg_if.port   cfg
);
   logic [2:0] sck_q, sck_d;
   logic [1:0] cs_q, cs_d, mosi_q, mosi_d;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] rx_q, rx_d, tx_q, tx_d;
   logic [4:0] addr_q, addr_d;
   logic       rd_q, rd_d, load_q, load_d, stb_q, stb_d;
   logic       rise, fall, act;

   // two-stage synchronisers; taps past stage 2 only
   assign rise = sck_q[1] & ~sck_q[2];
   assign fall = ~sck_q[1] & sck_q[2];
   assign act  = ~cs_q[1];

   always_comb begin
      sck_d  = {sck_q[1:0], sck_in};
      cs_d   = {cs_q[0], cs_n_in};
      mosi_d = {mosi_q[0], mosi_in};
      cnt_d  = cnt_q;
      rx_d   = rx_q;
      tx_d   = tx_q;
      addr_d = addr_q;
      rd_d   = rd_q;
      load_d = 1'b0;
      stb_d  = 1'b0;
      if (!act) begin
         cnt_d = 5'h00;
         rd_d  = 1'b0;
      end else if (rise && cnt_q < PFC_FRAME_BITS) begin
         rx_d  = {rx_q[6:0], mosi_q[1]};
         cnt_d = cnt_q + 5'h01;
         if (cnt_q == PFC_CMD_BITS - 5'h01) begin
            // command byte: bit 7 read, bits 4..0 address
            rd_d   = rx_q[6];
            addr_d = {rx_q[3:0], mosi_q[1]};
            load_d = 1'b1;
         end
         if (cnt_q == PFC_FRAME_BITS - 5'h01) begin
            stb_d = ~rd_q;
         end
      end else if (fall && cnt_q > PFC_CMD_BITS) begin
         tx_d = {tx_q[6:0], 1'b0};
      end
      if (load_q) begin
         tx_d = cfg.rdata;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         sck_q  <= 3'b000;
         cs_q   <= 2'b11;
         mosi_q <= 2'b00;
         cnt_q  <= 5'h00;
         rx_q   <= 8'h00;
         tx_q   <= 8'h00;
         addr_q <= 5'h00;
         rd_q   <= 1'b0;
         load_q <= 1'b0;
         stb_q  <= 1'b0;
      end else begin
         sck_q  <= sck_d;
         cs_q   <= cs_d;
         mosi_q <= mosi_d;
         cnt_q  <= cnt_d;
         rx_q   <= rx_d;
         tx_q   <= tx_d;
         addr_q <= addr_d;
         rd_q   <= rd_d;
         load_q <= load_d;
         stb_q  <= stb_d;
      end
   end

   assign cfg.wr_stb = stb_q;
   assign cfg.addr   = addr_q;
   assign cfg.wdata  = rx_q;
   assign miso_out    = tx_q[7];
   assign miso_oe_out = act & rd_q & (cnt_q >= PFC_CMD_BITS);
endmodule

// ---- pfc_clk_div.sv ----
// reference clock output divider
`timescale 1ns/100ps
module pfc_clk_div
   import pfc_pkg::*;
(
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       sys_rst_in,
   // control
   input  wire logic       en_in,
   input  wire logic [4:0] div_in,
   // output
   output logic            clk_out
);
   logic [4:0] cnt_q, cnt_d;
   logic       tog_q, tog_d;

   // half period of div_in cycles, so period is twice div_in
   always_comb begin
      cnt_d = cnt_q + 5'h01;
      tog_d = tog_q;
      if (!en_in || div_in == 5'h00) begin
         cnt_d = 5'h00;
         tog_d = 1'b0;
      end else if (cnt_q >= div_in - 5'h01) begin
         cnt_d = 5'h00;
         tog_d = ~tog_q;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         cnt_q <= 5'h00;
         tog_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tog_q <= tog_d;
      end
   end

   // zero divider passes the reference itself
   assign clk_out = en_in & ((div_in == 5'h00) ? mclk_in : tog_q);
endmodule

// ---- pfc_top.sv ----
// packet framing configuration and status registers
// Operation
// - sync bytes used per sync length field
// - interpolation cutoff field, default 0111
// - power field: 13 dBm minus N steps
// - clock output enable, on by default
// - divider: zero passes, else divide 2N
// - manchester enable both directions, default off
// - fixed format: length field is payload length
// - variable: length is receive maximum only
// - eight-bit node address, default zero
// - format bit: 0 fixed, 1 variable
// - preamble one to four bytes, default three
// - whitening enable both directions, default off
// - crc enable append and check, default on
// - address filter modes off/node/+00/+00+ff
// - read-only crc pass flag
// - autoclear zero empties fifo on failure
// - standby fifo access: 0 write, 1 read
`timescale 1ns/100ps
module pfc_top
   import pfc_pkg::*;
(
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       sys_rst_in,
   // serial configuration port
   input  wire logic       sck_in,
   input  wire logic       mosi_in,
   input  wire logic       cs_n_in,
   output logic            miso_out,
   output logic            miso_oe_out,
   // packet engine status
   input  wire logic [1:0] sync_size_in,
   input  wire logic       rx_addr_valid_in,
   input  wire logic [7:0] rx_addr_in,
   input  wire logic       crc_done_in,
   input  wire logic       crc_ok_in,
   // packet engine settings
   output logic [31:0]     sync_word_out,
   output logic [3:0]      sync_byte_used_out,
   output logic [3:0]      tx_interp_cutoff_out,
   output logic [2:0]      tx_power_step_out,
   output logic            manchester_on_out,
   output logic            whitening_on_out,
   output logic            crc_on_out,
   output logic            var_length_out,
   output logic [6:0]      tx_length_out,
   output logic            tx_length_used_out,
   output logic [6:0]      rx_length_out,
   output logic [2:0]      preamble_bytes_out,
   output logic            stby_fifo_read_out,
   // receive verdicts
   output logic            addr_verdict_out,
   output logic            addr_accept_out,
   output logic            fifo_clear_out,
   // reference clock output
   output logic            clkout_out
);
   pfc_cfg_if cfg ();

   logic [7:0] sync3_q, sync2_q, sync1_q, sync0_q;
   logic [7:0] sync3_d, sync2_d, sync1_d, sync0_d;
   logic [7:0] txset_q, txset_d, clko_q, clko_d, code_q, code_d;
   logic [7:0] node_q, node_d, fmt_q, fmt_d, fifo_q, fifo_d;
   logic       verd_q, verd_d, acc_q, acc_d, clr_q, clr_d;
   logic       hit;
   logic [7:0] rdata;

   pfc_spi_port u_port (
      .mclk_in     (mclk_in),
      .sys_rst_in  (sys_rst_in),
      .sck_in      (sck_in),
      .mosi_in     (mosi_in),
      .cs_n_in     (cs_n_in),
      .miso_out    (miso_out),
      .miso_oe_out (miso_oe_out),
      .cfg         (cfg.port)
   );

   // register writes and packet events
   always_comb begin
      sync3_d = sync3_q;
      sync2_d = sync2_q;
      sync1_d = sync1_q;
      sync0_d = sync0_q;
      txset_d = txset_q;
      clko_d  = clko_q;
      code_d  = code_q;
      node_d  = node_q;
      fmt_d   = fmt_q;
      fifo_d  = fifo_q;
      if (cfg.wr_stb) begin
         unique case (cfg.addr)
            PFC_SYNC3_OFS: sync3_d = cfg.wdata;
            PFC_SYNC2_OFS: sync2_d = cfg.wdata;
            PFC_SYNC1_OFS: sync1_d = cfg.wdata;
            PFC_SYNC0_OFS: sync0_d = cfg.wdata;
            PFC_TXSET_OFS: txset_d = cfg.wdata;
            PFC_CLKO_OFS:  clko_d  = cfg.wdata;
            PFC_CODE_OFS:  code_d  = cfg.wdata;
            PFC_NODE_OFS:  node_d  = cfg.wdata;
            // crc flag keeps its value over host writes
            PFC_FMT_OFS:   fmt_d   = {cfg.wdata[7:1],
                                      fmt_q[PFC_CRC_OK_BIT]};
            PFC_FIFO_OFS:  fifo_d  = cfg.wdata;
            default: ;
         endcase
      end
      // crc result taken at end of each packet, held until next
      if (crc_done_in) begin
         fmt_d[PFC_CRC_OK_BIT] = crc_ok_in;
      end
   end

   // address filter decision
   always_comb begin
      hit = (rx_addr_in == node_q);
      unique case (pfc_afilt_e'(fmt_q[PFC_AFILT_LSB +: 2]))
         PFC_AF_OFF:  hit = 1'b1;
         PFC_AF_NODE: hit = (rx_addr_in == node_q);
         PFC_AF_N00:  hit = (rx_addr_in == node_q) ||
                            (rx_addr_in == PFC_BCAST_LO);
         PFC_AF_NALL: hit = (rx_addr_in == node_q) ||
                            (rx_addr_in == PFC_BCAST_LO) ||
                            (rx_addr_in == PFC_BCAST_HI);
      endcase
      verd_d = rx_addr_valid_in;
      acc_d  = rx_addr_valid_in ? hit : acc_q;
      // fifo emptied on failure unless autoclear bit is set
      clr_d  = crc_done_in & crc_on_out & ~crc_ok_in &
               ~fifo_q[PFC_AUTOCLR_BIT];
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         sync3_q <= PFC_SYNC_RST;
         sync2_q <= PFC_SYNC_RST;
         sync1_q <= PFC_SYNC_RST;
         sync0_q <= PFC_SYNC_RST;
         txset_q <= PFC_TXSET_RST;
         clko_q  <= PFC_CLKO_RST;
         code_q  <= PFC_CODE_RST;
         node_q  <= PFC_NODE_RST;
         fmt_q   <= PFC_FMT_RST;
         fifo_q  <= PFC_FIFO_RST;
         verd_q  <= 1'b0;
         acc_q   <= 1'b0;
         clr_q   <= 1'b0;
      end else begin
         sync3_q <= sync3_d;
         sync2_q <= sync2_d;
         sync1_q <= sync1_d;
         sync0_q <= sync0_d;
         txset_q <= txset_d;
         clko_q  <= clko_d;
         code_q  <= code_d;
         node_q  <= node_d;
         fmt_q   <= fmt_d;
         fifo_q  <= fifo_d;
         verd_q  <= verd_d;
         acc_q   <= acc_d;
         clr_q   <= clr_d;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      unique case (cfg.addr)
         PFC_SYNC3_OFS: rdata = sync3_q;
         PFC_SYNC2_OFS: rdata = sync2_q;
         PFC_SYNC1_OFS: rdata = sync1_q;
         PFC_SYNC0_OFS: rdata = sync0_q;
         PFC_TXSET_OFS: rdata = txset_q;
         PFC_CLKO_OFS:  rdata = clko_q;
         PFC_CODE_OFS:  rdata = code_q;
         PFC_NODE_OFS:  rdata = node_q;
         PFC_FMT_OFS:   rdata = fmt_q;
         PFC_FIFO_OFS:  rdata = fifo_q;
         default:       rdata = 8'h00;
      endcase
   end
   assign cfg.rdata = rdata;

   // settings towards the packet engine
   assign sync_word_out = {sync3_q, sync2_q, sync1_q, sync0_q};
   assign sync_byte_used_out = {1'b1,
                                sync_size_in != 2'b00,
                                sync_size_in[1],
                                sync_size_in == 2'b11};
   assign tx_interp_cutoff_out = txset_q[PFC_INTERP_LSB +: 4];
   assign tx_power_step_out    = txset_q[PFC_POWER_LSB +: 3];
   assign manchester_on_out    = code_q[PFC_MANCH_BIT];
   assign var_length_out       = fmt_q[PFC_FORMAT_BIT];
   assign tx_length_out        = code_q[6:0];
   assign tx_length_used_out   = ~fmt_q[PFC_FORMAT_BIT];
   assign rx_length_out        = code_q[6:0];
   assign preamble_bytes_out   = {1'b0, fmt_q[PFC_PREAMB_LSB +: 2]} +
                                 3'b001;
   assign whitening_on_out     = fmt_q[PFC_WHITE_BIT];
   assign crc_on_out           = fmt_q[PFC_CRC_EN_BIT];
   assign stby_fifo_read_out   = fifo_q[PFC_STBY_RD_BIT];
   assign addr_verdict_out     = verd_q;
   assign addr_accept_out      = acc_q;
   assign fifo_clear_out       = clr_q;

   pfc_clk_div u_clkdiv (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .en_in      (clko_q[PFC_CLKO_EN_BIT]),
      .div_in     (clko_q[PFC_CLKO_DIV_LSB +: 5]),
      .clk_out    (clkout_out)
   );

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_fail_done;
      crc_done_in && !crc_ok_in && crc_on_out && !fifo_q[PFC_AUTOCLR_BIT];
   endsequence
   a_fifo_clear_fail: assert property (s_fail_done |=> fifo_clear_out)
      else $error("fifo not cleared after crc failure");
   a_fifo_keep_off: assert property (fifo_clear_out |->
      $past(crc_done_in) && !$past(crc_ok_in) &&
      !$past(fifo_q[PFC_AUTOCLR_BIT]))
      else $error("fifo cleared without failing crc");
   a_crc_off_keep: assert property (crc_done_in && !crc_on_out |=>
      !fifo_clear_out)
      else $error("fifo cleared with crc check off");
   a_crc_flag_take: assert property (crc_done_in |=>
      fmt_q[PFC_CRC_OK_BIT] == $past(crc_ok_in))
      else $error("crc flag not updated at packet end");
   a_crc_flag_hold: assert property (!crc_done_in |=>
      $stable(fmt_q[PFC_CRC_OK_BIT]))
      else $error("crc flag changed without packet end");
   a_addr_node_hit: assert property (rx_addr_valid_in &&
      fmt_q[2:1] != 2'b00 && rx_addr_in == node_q |=> addr_accept_out)
      else $error("node address rejected");
   a_addr_bcast_ff: assert property (rx_addr_valid_in &&
      fmt_q[2:1] != 2'b11 && fmt_q[2:1] != 2'b00 &&
      rx_addr_in == PFC_BCAST_HI &&
      rx_addr_in != node_q |=> !addr_accept_out)
      else $error("0xff accepted outside widest mode");
   a_addr_off_all: assert property (rx_addr_valid_in &&
      fmt_q[2:1] == 2'b00 |=> addr_accept_out && addr_verdict_out)
      else $error("filter off rejected a packet");
   a_verdict_pulse: assert property (rx_addr_valid_in |=>
      addr_verdict_out)
      else $error("address verdict missing");
   a_accept_hold: assert property (!rx_addr_valid_in |=>
      !addr_verdict_out && $stable(addr_accept_out))
      else $error("address verdict changed without packet");
   a_sync_use_top: assert property (sync_byte_used_out[0] |->
      sync_byte_used_out[1] && sync_byte_used_out[2])
      else $error("sync bytes enabled out of order");
   a_preamble_len: assert property (preamble_bytes_out ==
      3'(fmt_q[6:5]) + 3'd1 && preamble_bytes_out != 3'd0)
      else $error("preamble length wrong");
   a_write_node_reg: assert property (cfg.wr_stb &&
      cfg.addr == PFC_NODE_OFS |=> node_q == $past(cfg.wdata))
      else $error("node address write lost");
   a_clko_off_low: assert property (!clko_q[PFC_CLKO_EN_BIT]
      |-> !clkout_out)
      else $error("clock output active while disabled");

   // host writes reach the packet engine settings one cycle later
   sequence s_wr_txset;
      cfg.wr_stb && cfg.addr == PFC_TXSET_OFS;
   endsequence
   sequence s_wr_code;
      cfg.wr_stb && cfg.addr == PFC_CODE_OFS;
   endsequence
   sequence s_wr_fmt;
      cfg.wr_stb && cfg.addr == PFC_FMT_OFS;
   endsequence
   sequence s_wr_fifo;
      cfg.wr_stb && cfg.addr == PFC_FIFO_OFS;
   endsequence
   sequence s_wr_sync0;
      cfg.wr_stb && cfg.addr == PFC_SYNC0_OFS;
   endsequence

   a_txset_cutoff: assert property (s_wr_txset |=>
      tx_interp_cutoff_out == $past(cfg.wdata[7:4]))
      else $error("interpolation cutoff write lost");
   a_txset_power: assert property (s_wr_txset |=>
      tx_power_step_out == $past(cfg.wdata[3:1]))
      else $error("power step write lost");
   a_code_manch: assert property (s_wr_code |=>
      manchester_on_out == $past(cfg.wdata[7]))
      else $error("manchester enable write lost");
   a_code_length: assert property (s_wr_code |=>
      rx_length_out == $past(cfg.wdata[6:0]))
      else $error("payload length write lost");
   a_fmt_fields: assert property (s_wr_fmt |=>
      var_length_out == $past(cfg.wdata[7]) &&
      whitening_on_out == $past(cfg.wdata[4]) &&
      crc_on_out == $past(cfg.wdata[3]))
      else $error("packet format write lost");
   a_fifo_stby: assert property (s_wr_fifo |=>
      stby_fifo_read_out == $past(cfg.wdata[6]))
      else $error("standby access write lost");
   a_sync_low_byte: assert property (s_wr_sync0 |=>
      sync_word_out[7:0] == $past(cfg.wdata))
      else $error("sync word write lost");
endmodule

// ---- pfc_host_model.sv ----
// host microcontroller driving the serial configuration port
`timescale 1ns/100ps
module pfc_host_model
   import pfc_pkg::*;
#(
   parameter int HALF = 5
)
(
   // clock
   input  wire logic mclk_in,
   // serial pins
   output logic      sck_out,
   output logic      mosi_out,
   output logic      cs_n_out,
   input  wire logic miso_in,
   input  wire logic miso_oe_in
);
   initial begin
      sck_out  = 1'b0;
      mosi_out = 1'b0;
      cs_n_out = 1'b1;
   end
   // one frame: command byte then data byte, msb first
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] data,
                       output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, data};
      rd = 8'h00;
      @(posedge mclk_in);
      #1 cs_n_out = 1'b0;
      for (int i = 0; i < 16; i++) begin
         mosi_out = sh[15-i];
         repeat (HALF) @(posedge mclk_in);
         #1 sck_out = 1'b1;
         // an undriven pin reads as unknown, never as data
         if (i >= 8) rd = {rd[6:0], miso_oe_in ? miso_in : 1'bx};
         repeat (HALF) @(posedge mclk_in);
         #1 sck_out = 1'b0;
      end
      repeat (HALF) @(posedge mclk_in);
      #1 cs_n_out = 1'b1;
      // released data line shows the inverse of its last bit
      mosi_out = ~mosi_out;
      repeat (4) @(posedge mclk_in);
      #1;
   endtask
endmodule

// ---- tb.sv ----
// self-checking testbench of the packet framing configuration block
`timescale 1ns/100ps
module tb
   import pfc_pkg::*;
;
   logic        mclk_in, sys_rst_in, sck, mosi, cs_n, miso, miso_oe;
   logic [1:0]  sync_size;
   logic        rx_av, crc_done, crc_ok;
   logic [7:0]  rx_addr;
   logic [31:0] sync_word;
   logic [3:0]  byte_used, cutoff;
   logic [2:0]  power, preamble;
   logic        manch, white, crc_on, var_len, tx_used, stby_rd;
   logic [6:0]  tx_len, rx_len;
   logic        verdict, accept, fifo_clr, clkout;
   int          mismatches, comparisons;
   localparam logic [7:0] RV [10] = '{PFC_SYNC_RST, PFC_SYNC_RST,
      PFC_SYNC_RST, PFC_SYNC_RST, PFC_TXSET_RST, PFC_CLKO_RST,
      PFC_CODE_RST, PFC_NODE_RST, PFC_FMT_RST, PFC_FIFO_RST};
   localparam logic [7:0] ADR [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};

   pfc_top u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .sck_in(sck), .mosi_in(mosi), .cs_n_in(cs_n), .miso_out(miso),
      .miso_oe_out(miso_oe), .sync_size_in(sync_size),
      .rx_addr_valid_in(rx_av), .rx_addr_in(rx_addr),
      .crc_done_in(crc_done), .crc_ok_in(crc_ok),
      .sync_word_out(sync_word), .sync_byte_used_out(byte_used),
      .tx_interp_cutoff_out(cutoff), .tx_power_step_out(power),
      .manchester_on_out(manch), .whitening_on_out(white),
      .crc_on_out(crc_on), .var_length_out(var_len),
      .tx_length_out(tx_len), .tx_length_used_out(tx_used),
      .rx_length_out(rx_len), .preamble_bytes_out(preamble),
      .stby_fifo_read_out(stby_rd), .addr_verdict_out(verdict),
      .addr_accept_out(accept), .fifo_clear_out(fifo_clr),
      .clkout_out(clkout));
   pfc_host_model u_host (.mclk_in(mclk_in), .sck_out(sck),
      .mosi_out(mosi), .cs_n_out(cs_n), .miso_in(miso),
      .miso_oe_in(miso_oe));

   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   task chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task finish_test;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task tick;
      @(posedge mclk_in);
      #1;
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] r;
      u_host.xfer({3'b000, a}, d, r);
   endtask
   task rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
      logic [7:0] r;
      u_host.xfer({3'b100, a}, 8'h00, r);
      chk(nm, 32'(r), 32'(e));
   endtask
   task t_reset;
      for (int i = 0; i < 10; i++)
         rdc("reset", PFC_SYNC3_OFS + 5'(i), RV[i]);
      chk("preamble", 32'(preamble), 32'h3);
      chk("crc on", 32'(crc_on), 32'h1);
      chk("variable", 32'(var_len), 32'h0);
      chk("standby read", 32'(stby_rd), 32'h0);
      chk("cutoff", 32'(cutoff), 32'h7);
      chk("power", 32'(power), 32'h1);
      chk("manchester", 32'(manch), 32'h0);
      chk("whitening", 32'(white), 32'h0);
      wr(PFC_TXSET_OFS, 8'ha6);
      chk("cutoff set", 32'(cutoff), 32'ha);
      chk("power set", 32'(power), 32'h3);
      wr(5'h15, 8'h77);
      rdc("unmapped", 5'h15, 8'h00);
   endtask
   task t_sync;
      wr(PFC_SYNC3_OFS, 8'ha1);
      wr(PFC_SYNC2_OFS, 8'hb2);
      wr(PFC_SYNC1_OFS, 8'hc3);
      wr(PFC_SYNC0_OFS, 8'hd4);
      chk("sync word", sync_word, 32'ha1b2_c3d4);
      for (int s = 0; s < 4; s++) begin
         sync_size = 2'(s);
         tick;
         chk("bytes used", 32'(byte_used),
             32'({1'b1, s != 0, s >= 2, s == 3}));
      end
   endtask
   task t_length;
      wr(PFC_CODE_OFS, 8'hc5);
      chk("manchester", 32'(manch), 32'h1);
      chk("tx length", 32'(tx_len), 32'h45);
      chk("rx length", 32'(rx_len), 32'h45);
      chk("tx used", 32'(tx_used), 32'h1);
      chk("variable", 32'(var_len), 32'h0);
      wr(PFC_FMT_OFS, 8'hc8);
      chk("variable", 32'(var_len), 32'h1);
      chk("tx unused", 32'(tx_used), 32'h0);
      chk("rx maximum", 32'(rx_len), 32'h45);
      for (int p = 0; p < 4; p++) begin
         wr(PFC_FMT_OFS, {1'b0, 2'(p), 5'b11000});
         chk("preamble", 32'(preamble), 32'(p + 1));
         chk("whitening", 32'(white), 32'h1);
         chk("crc on", 32'(crc_on), 32'h1);
      end
      wr(PFC_FMT_OFS, 8'h40);
      chk("crc off", 32'(crc_on), 32'h0);
      wr(PFC_FIFO_OFS, 8'h40);
      chk("standby read", 32'(stby_rd), 32'h1);
      rdc("fifo control", PFC_FIFO_OFS, 8'h40);
   endtask
   task t_filter;
      logic e;
      wr(PFC_NODE_OFS, 8'h5a);
      rdc("node", PFC_NODE_OFS, 8'h5a);
      for (int m = 0; m < 4; m++) begin
         wr(PFC_FMT_OFS, 8'h48 | {5'b00000, 2'(m), 1'b0});
         for (int j = 0; j < 4; j++) begin
            e = (m == 0) || (ADR[j] == 8'h5a) ||
                (m >= 2 && ADR[j] == PFC_BCAST_LO) ||
                (m == 3 && ADR[j] == PFC_BCAST_HI);
            rx_addr = ADR[j];
            rx_av = 1'b1;
            tick;
            rx_av = 1'b0;
            chk("verdict", 32'(verdict), 32'h1);
            chk("accept", 32'(accept), 32'(e));
            tick;
            chk("verdict end", 32'(verdict), 32'h0);
            chk("accept held", 32'(accept), 32'(e));
         end
      end
   endtask
   task crc_ev(input logic ok, input logic clr);
      crc_ok = ok;
      crc_done = 1'b1;
      tick;
      crc_done = 1'b0;
      chk("fifo clear", 32'(fifo_clr), 32'(clr));
      tick;
      chk("clear end", 32'(fifo_clr), 32'h0);
   endtask
   task t_crc;
      wr(PFC_FMT_OFS, 8'h48);
      wr(PFC_FIFO_OFS, 8'h00);
      crc_ev(1'b1, 1'b0);
      rdc("crc pass", PFC_FMT_OFS, 8'h49);
      crc_ev(1'b0, 1'b1);
      rdc("crc fail", PFC_FMT_OFS, 8'h48);
      wr(PFC_FIFO_OFS, 8'h80);
      crc_ev(1'b0, 1'b0);
      crc_ev(1'b1, 1'b0);
      repeat (20) tick;
      rdc("crc held", PFC_FMT_OFS, 8'h49);
      wr(PFC_FMT_OFS, 8'h48);
      rdc("crc read only", PFC_FMT_OFS, 8'h49);
   endtask
   task rises(output int n);
      logic prev;
      n = 0;
      tick;
      prev = clkout;
      repeat (80) begin
         tick;
         if (clkout === 1'b1 && prev === 1'b0) n++;
         prev = clkout;
      end
   endtask
   task t_clkout;
      int n;
      wr(PFC_CLKO_OFS, 8'h88);
      rises(n);
      chk("div two rises", 32'(n), 32'd20);
      wr(PFC_CLKO_OFS, 8'h80);
      tick;
      chk("div zero high", 32'(clkout), 32'h1);
      #5;
      chk("div zero low", 32'(clkout), 32'h0);
      wr(PFC_CLKO_OFS, 8'h08);
      rises(n);
      chk("disabled rises", 32'(n), 32'd0);
      chk("disabled level", 32'(clkout), 32'h0);
   endtask

   initial begin
      #200_000;
      mismatches++;
      finish_test;
   end
   initial begin
      mismatches = 0;
      comparisons = 0;
      sys_rst_in = 1'b1;
      sync_size = 2'b00;
      rx_av = 1'b0;
      rx_addr = 8'h00;
      crc_done = 1'b0;
      crc_ok = 1'b0;
      repeat (4) @(posedge mclk_in);
      #1 sys_rst_in = 1'b0;
      repeat (3) tick;
      t_reset;
      t_sync;
      t_length;
      t_filter;
      t_crc;
      t_clkout;
      finish_test;
   end
endmodule
